// >>> logic/dcps_regs.vh
// Register offsets, field positions and reset values of the PWM serialiser
`ifndef DCPS_REGS_VH
`define DCPS_REGS_VH

`define DCPS_OFF_CTL        8'h00
`define DCPS_OFF_STA        8'h04
`define DCPS_OFF_DMA_REQUEST_CONFIG       8'h08
`define DCPS_OFF_CH1_PERIOD_LENGTH       8'h10
`define DCPS_OFF_CH1_OUTPUT_WORD       8'h14
`define DCPS_OFF_FIFO       8'h18
`define DCPS_OFF_CH2_PERIOD_LENGTH       8'h20
`define DCPS_OFF_CH2_OUTPUT_WORD       8'h24

`define DCPS_CTL_RESET      32'h00000000
`define DCPS_CTL_MASK       32'h0000BFBF
`define DCPS_DMA_REQUEST_CONFIG_RESET     32'h00000707
`define DCPS_RNG_RESET      32'h00000020
`define DCPS_DAT_RESET      32'h00000000

`define DCPS_CH_STRIDE      8
`define DCPS_BIT_EN         0
`define DCPS_BIT_SER        1
`define DCPS_BIT_HOLD       2
`define DCPS_BIT_IDLE       3
`define DCPS_BIT_INV        4
`define DCPS_BIT_FIFO       5
`define DCPS_BIT_FLUSH      6
`define DCPS_BIT_MS         7

`define DCPS_STA_FULL       0
`define DCPS_STA_EMPTY      1
`define DCPS_STA_WERR       2
`define DCPS_STA_GAP1       4
`define DCPS_STA_GAP2       5
`define DCPS_STA_ST1        9
`define DCPS_STA_ST2        10

`define DCPS_WORD_BITS      32
`define DCPS_FIFO_DEPTH     64
`define DCPS_FIFO_AW        6

`endif

// >>> logic/dcps_fifo.v
// Shared 64-word transmit queue with one-shot flush
module dcps_fifo (
   input  wire        sys_clk_i,
   input  wire        nrst_i,
   input  wire        flush_i,
   input  wire        in_valid_i,
   input  wire [31:0] in_data_i,
   output wire        in_ready_o,
   output wire        out_valid_o,
   output wire [31:0] out_data_o,
   input  wire        out_ready_i,
   output wire        full_o,
   output wire        empty_o
);
`include "dcps_regs.vh"

   reg  [31:0]               mem [0:`DCPS_FIFO_DEPTH-1];
   reg  [`DCPS_FIFO_AW-1:0]  wr_ptr_reg;
   reg  [`DCPS_FIFO_AW-1:0]  rd_ptr_reg;
   reg  [`DCPS_FIFO_AW:0]    count_reg;
   wire                      push;
   wire                      pop;

   assign full_o      = (count_reg == `DCPS_FIFO_DEPTH);
   assign empty_o     = (count_reg == 0);
   assign in_ready_o  = !full_o;
   assign out_valid_o = !empty_o;
   assign out_data_o  = mem[rd_ptr_reg];
   assign push        = in_valid_i && !full_o;
   assign pop         = out_ready_i && !empty_o;

   always @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   always @(posedge sys_clk_i) begin
      if (!nrst_i || flush_i) begin
         wr_ptr_reg <= {`DCPS_FIFO_AW{1'b0}};
         rd_ptr_reg <= {`DCPS_FIFO_AW{1'b0}};
         count_reg  <= {(`DCPS_FIFO_AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule

// >>> logic/dcps_buf2.v
// Two-entry buffer between the queue and the channels
module dcps_buf2 (
   input  wire        sys_clk_i,
   input  wire        nrst_i,
   input  wire        flush_i,
   input  wire        in_valid_i,
   input  wire [31:0] in_data_i,
   output wire        in_ready_o,
   output wire        out_valid_o,
   output wire [31:0] out_data_o,
   input  wire        out_ready_i
);

   reg  [31:0] d0_reg;
   reg  [31:0] d1_reg;
   reg         v0_reg;
   reg         v1_reg;
   wire        push;
   wire        pop;

   // Ready only from own state, so a channel stall never loops back combinationally
   assign in_ready_o  = !v1_reg;
   assign out_valid_o = v0_reg;
   assign out_data_o  = d0_reg;
   assign push        = in_valid_i && !v1_reg;
   assign pop         = out_ready_i && v0_reg;

   always @(posedge sys_clk_i) begin
      if (!nrst_i || flush_i) begin
         d0_reg <= 32'h00000000;
         d1_reg <= 32'h00000000;
         v0_reg <= 1'b0;
         v1_reg <= 1'b0;
      end else if (pop) begin
         if (v1_reg) begin
            d0_reg <= d1_reg;
         end else begin
            d0_reg <= in_data_i;
            v0_reg <= push;
         end
         if (push && v1_reg) begin
            d1_reg <= in_data_i;
         end
         v1_reg <= 1'b0;
      end else if (push) begin
         if (!v0_reg) begin
            d0_reg <= in_data_i;
            v0_reg <= 1'b1;
         end else begin
            d1_reg <= in_data_i;
            v1_reg <= 1'b1;
         end
      end
   end

endmodule

// >>> logic/dcps_top.v
// Two-channel PWM / serialiser with shared queue and register port
module dcps_top (
   input  wire        sys_clk_i,
   input  wire        nrst_i,
   input  wire        pwm_clk_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   output reg         ch1_pwm_o,
   output reg         ch2_pwm_o
);
`include "dcps_regs.vh"

   localparam ST_IDLE   = 1'b0;
   localparam ST_SEND   = 1'b1;
   localparam MODE_ALGO = 2'b00;
   localparam MODE_MS   = 2'b01;
   localparam MODE_SER  = 2'b10;

   function hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   reg  [31:0] ctl_reg;
   reg  [31:0] dma_request_config_reg;
   reg  [31:0] rng_reg [0:1];
   reg  [31:0] dat_reg [0:1];
   reg         werr_reg;
   reg  [1:0]  gap_reg;
   reg         turn_reg;
   reg         pclk_s1_reg;
   reg         pclk_s2_reg;
   reg         pclk_s3_reg;
   wire [1:0]  out_w;

   wire        wr_en;
   wire        rd_setup;
   wire        fifo_wr;
   wire        flush;
   wire        tick;
   wire        q_in_ready;
   wire        q_out_valid;
   wire [31:0] q_out_data;
   wire        q_full;
   wire        q_empty;
   wire        b_in_ready;
   wire        b_valid;
   wire [31:0] b_data;
   wire [1:0]  pop_w;
   wire [1:0]  gap_w;
   wire [1:0]  st_w;
   wire        both_fifo;
   wire        grant;
   wire        all_empty;
   wire [31:0] sta_val;

   assign wr_en    = psel_i && penable_i && pwrite_i && pready_o;
   assign rd_setup = psel_i && !penable_i;
   assign fifo_wr  = wr_en && hit(paddr_i, `DCPS_OFF_FIFO);
   assign flush    = wr_en && hit(paddr_i, `DCPS_OFF_CTL)
                     && pwdata_i[`DCPS_BIT_FLUSH];
   assign all_empty = q_empty && !b_valid;
   assign sta_val  = (32'h00000001 << `DCPS_STA_ST2) & {32{st_w[1]}}
                   | (32'h00000001 << `DCPS_STA_ST1) & {32{st_w[0]}}
                   | (32'h00000001 << `DCPS_STA_GAP2) & {32{gap_reg[1]}}
                   | (32'h00000001 << `DCPS_STA_GAP1) & {32{gap_reg[0]}}
                   | (32'h00000001 << `DCPS_STA_WERR) & {32{werr_reg}}
                   | (32'h00000001 << `DCPS_STA_EMPTY) & {32{all_empty}}
                   | (32'h00000001 << `DCPS_STA_FULL) & {32{q_full}};

   // PWM clock is a foreign pin: two flops, then edge detect on the second
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         pclk_s1_reg <= 1'b0;
         pclk_s2_reg <= 1'b0;
         pclk_s3_reg <= 1'b0;
      end else begin
         pclk_s1_reg <= pwm_clk_i;
         pclk_s2_reg <= pclk_s1_reg;
         pclk_s3_reg <= pclk_s2_reg;
      end
   end

   assign tick = pclk_s2_reg && !pclk_s3_reg;

   // Register port: zero-wait, read data latched in the setup phase
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         prdata_o  <= 32'h00000000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= rd_setup;
         pslverr_o <= 1'b0;
         if (rd_setup) begin
            prdata_o <= 32'h00000000;
            if (hit(paddr_i, `DCPS_OFF_CTL)) begin
               prdata_o <= ctl_reg;
            end else if (hit(paddr_i, `DCPS_OFF_STA)) begin
               prdata_o <= sta_val;
            end else if (hit(paddr_i, `DCPS_OFF_DMA_REQUEST_CONFIG)) begin
               prdata_o <= dma_request_config_reg;
            end else if (hit(paddr_i, `DCPS_OFF_CH1_PERIOD_LENGTH)) begin
               prdata_o <= rng_reg[0];
            end else if (hit(paddr_i, `DCPS_OFF_CH1_OUTPUT_WORD)) begin
               prdata_o <= dat_reg[0];
            end else if (hit(paddr_i, `DCPS_OFF_CH2_PERIOD_LENGTH)) begin
               prdata_o <= rng_reg[1];
            end else if (hit(paddr_i, `DCPS_OFF_CH2_OUTPUT_WORD)) begin
               prdata_o <= dat_reg[1];
            end else if (!pwrite_i && !hit(paddr_i, `DCPS_OFF_FIFO)) begin
               pslverr_o <= 1'b1;
            end
         end
      end
   end

   // Writable at any time, whether channels run or not
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         ctl_reg    <= `DCPS_CTL_RESET;
         dma_request_config_reg   <= `DCPS_DMA_REQUEST_CONFIG_RESET;
         rng_reg[0] <= `DCPS_RNG_RESET;
         rng_reg[1] <= `DCPS_RNG_RESET;
         dat_reg[0] <= `DCPS_DAT_RESET;
         dat_reg[1] <= `DCPS_DAT_RESET;
      end else if (wr_en) begin
         if (hit(paddr_i, `DCPS_OFF_CTL)) begin
            ctl_reg <= pwdata_i & `DCPS_CTL_MASK;
         end
         if (hit(paddr_i, `DCPS_OFF_DMA_REQUEST_CONFIG)) begin
            dma_request_config_reg <= pwdata_i;
         end
         if (hit(paddr_i, `DCPS_OFF_CH1_PERIOD_LENGTH)) begin
            rng_reg[0] <= pwdata_i;
         end
         if (hit(paddr_i, `DCPS_OFF_CH1_OUTPUT_WORD)) begin
            dat_reg[0] <= pwdata_i;
         end
         if (hit(paddr_i, `DCPS_OFF_CH2_PERIOD_LENGTH)) begin
            rng_reg[1] <= pwdata_i;
         end
         if (hit(paddr_i, `DCPS_OFF_CH2_OUTPUT_WORD)) begin
            dat_reg[1] <= pwdata_i;
         end
      end
   end

   // Sticky flags: a new event beats a clear in the same cycle
   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         werr_reg <= 1'b0;
         gap_reg  <= 2'b00;
      end else begin
         if (fifo_wr && !q_in_ready) begin
            werr_reg <= 1'b1;
         end else if (wr_en && hit(paddr_i, `DCPS_OFF_STA)
                      && pwdata_i[`DCPS_STA_WERR]) begin
            werr_reg <= 1'b0;
         end
         if (gap_w[0]) begin
            gap_reg[0] <= 1'b1;
         end else if (wr_en && hit(paddr_i, `DCPS_OFF_STA)
                      && pwdata_i[`DCPS_STA_GAP1]) begin
            gap_reg[0] <= 1'b0;
         end
         if (gap_w[1]) begin
            gap_reg[1] <= 1'b1;
         end else if (wr_en && hit(paddr_i, `DCPS_OFF_STA)
                      && pwdata_i[`DCPS_STA_GAP2]) begin
            gap_reg[1] <= 1'b0;
         end
      end
   end

   dcps_fifo u_fifo (
      .sys_clk_i   (sys_clk_i),
      .nrst_i      (nrst_i),
      .flush_i     (flush),
      .in_valid_i  (fifo_wr),
      .in_data_i   (pwdata_i),
      .in_ready_o  (q_in_ready),
      .out_valid_o (q_out_valid),
      .out_data_o  (q_out_data),
      .out_ready_i (b_in_ready),
      .full_o      (q_full),
      .empty_o     (q_empty)
   );

   dcps_buf2 u_buf (
      .sys_clk_i   (sys_clk_i),
      .nrst_i      (nrst_i),
      .flush_i     (flush),
      .in_valid_i  (q_out_valid),
      .in_data_i   (q_out_data),
      .in_ready_o  (b_in_ready),
      .out_valid_o (b_valid),
      .out_data_o  (b_data),
      .out_ready_i (|pop_w)
   );

   // Lock-step sharing: words alternate, channel one first
   assign both_fifo = ctl_reg[`DCPS_BIT_FIFO] && ctl_reg[`DCPS_BIT_FIFO + `DCPS_CH_STRIDE];
   assign grant     = both_fifo ? turn_reg : !ctl_reg[`DCPS_BIT_FIFO];

   always @(posedge sys_clk_i) begin
      if (!nrst_i || flush || !both_fifo) begin
         turn_reg <= 1'b0;
      end else if (|pop_w) begin
         turn_reg <= !turn_reg;
      end
   end

   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : g_ch
         wire        en    = ctl_reg[`DCPS_BIT_EN   + c*`DCPS_CH_STRIDE];
         wire        ser   = ctl_reg[`DCPS_BIT_SER  + c*`DCPS_CH_STRIDE];
         wire        hold  = ctl_reg[`DCPS_BIT_HOLD + c*`DCPS_CH_STRIDE];
         wire        idle  = ctl_reg[`DCPS_BIT_IDLE + c*`DCPS_CH_STRIDE];
         wire        inv   = ctl_reg[`DCPS_BIT_INV  + c*`DCPS_CH_STRIDE];
         wire        usef  = ctl_reg[`DCPS_BIT_FIFO + c*`DCPS_CH_STRIDE];
         wire        ms    = ctl_reg[`DCPS_BIT_MS   + c*`DCPS_CH_STRIDE];
         wire [31:0] rng   = rng_reg[c];
         reg  [31:0] cnt_reg;
         reg  [31:0] word_reg;
         reg  [31:0] acc_reg;
         reg         st_reg;
         reg         have_reg;
         reg         out_bit_reg;
         reg  [31:0] word_next;
         reg         st_next;
         reg  [31:0] acc_next;
         reg         bit_next;
         reg  [1:0]  mode;
         reg  [32:0] sum;
         wire        at_start = (cnt_reg == 32'h00000000);
         wire        take = usef && b_valid && (grant == c);
         wire        run  = tick && en && (rng != 32'h00000000);

         assign pop_w[c] = run && at_start && take;
         assign gap_w[c] = run && at_start && usef && !take && !(hold && have_reg)
                           && (st_reg == ST_SEND);
         assign st_w[c]  = st_reg;
         assign out_w[c] = out_bit_reg;

         always @* begin
            word_next = word_reg;
            st_next   = st_reg;
            acc_next  = acc_reg;
            bit_next  = idle;
            sum       = 33'h000000000;
            mode      = ser ? MODE_SER : (ms ? MODE_MS : MODE_ALGO);
            if (at_start) begin
               if (!usef) begin
                  word_next = dat_reg[c];
                  st_next   = ST_SEND;
               end else if (take) begin
                  word_next = b_data;
                  st_next   = ST_SEND;
               end else if (hold && have_reg) begin
                  st_next   = ST_SEND;
               end else begin
                  st_next   = ST_IDLE;
               end
            end
            case (st_next)
               ST_SEND: begin
                  case (mode)
                     MODE_SER: begin
                        if (cnt_reg < `DCPS_WORD_BITS) begin
                           bit_next = word_next[5'd31 - cnt_reg[4:0]];
                        end
                     end
                     MODE_MS: begin
                        bit_next = (cnt_reg < word_next);
                     end
                     default: begin
                        sum = {1'b0, acc_reg} + {1'b0, word_next};
                        if (sum >= {1'b0, rng}) begin
                           bit_next = 1'b1;
                           acc_next = sum[31:0] - rng;
                        end else begin
                           bit_next = 1'b0;
                           acc_next = sum[31:0];
                        end
                     end
                  endcase
               end
               default: begin
                  bit_next = idle;
               end
            endcase
         end

         always @(posedge sys_clk_i) begin
            if (!nrst_i) begin
               cnt_reg  <= 32'h00000000;
               word_reg <= 32'h00000000;
               acc_reg  <= 32'h00000000;
               st_reg   <= ST_IDLE;
               have_reg <= 1'b0;
               out_bit_reg <= 1'b0;
            end else begin
               if (flush) begin
                  have_reg <= 1'b0;
               end else if (pop_w[c]) begin
                  have_reg <= 1'b1;
               end
               if (!en || rng == 32'h00000000) begin
                  cnt_reg    <= 32'h00000000;
                  acc_reg    <= 32'h00000000;
                  st_reg     <= ST_IDLE;
                  out_bit_reg <= idle ^ inv;
               end else if (run) begin
                  word_reg   <= word_next;
                  st_reg     <= st_next;
                  acc_reg    <= acc_next;
                  out_bit_reg <= bit_next ^ inv;
                  if (st_next == ST_IDLE) begin
                     cnt_reg <= 32'h00000000;
                  end else if (cnt_reg + 32'h00000001 >= rng) begin
                     cnt_reg <= 32'h00000000;
                  end else begin
                     cnt_reg <= cnt_reg + 32'h00000001;
                  end
               end
            end
         end
      end
   endgenerate

   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         ch1_pwm_o <= 1'b0;
         ch2_pwm_o <= 1'b0;
      end else begin
         ch1_pwm_o <= out_w[0];
         ch2_pwm_o <= out_w[1];
      end
   end

endmodule

// >>> testbench/dcps_properties.sv
// Register port assertions of the two-channel PWM serialiser
module dcps_properties (
   input wire logic        sys_clk_i,
   input wire logic        nrst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   logic setup;
   logic mapped;
   assign setup = psel_i && !penable_i;
   // Eight mapped offsets, all word aligned
   assign mapped = paddr_i[7:6] == 2'h0 && paddr_i[1:0] == 2'h0
                   && paddr_i[5:2] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};

   a_ready_after_setup: assert property (setup |=> pready_o)
      else $error("ready missing after setup");
   a_ready_one_cycle: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_ready_has_cause: assert property (pready_o |-> $past(setup))
      else $error("ready without setup");
   a_err_unmapped_read: assert property (
      setup && !pwrite_i && !mapped |=> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped read not refused");
   a_no_err_mapped: assert property (setup && mapped |=> !pslverr_o)
      else $error("error on mapped access");
   a_no_err_write: assert property (setup && pwrite_i |=> !pslverr_o)
      else $error("error on write");
   a_queue_reads_zero: assert property (
      setup && !pwrite_i && paddr_i == 8'h18 |=> prdata_o == 32'h0)
      else $error("queue input read not zero");
   a_ctl_reserved_zero: assert property (
      pready_o && !pwrite_i && paddr_i == 8'h00 |-> (prdata_o & 32'hFFFF4040) == 32'h0)
      else $error("control reads flush or reserved bit");
   a_sta_reserved_zero: assert property (
      pready_o && !pwrite_i && paddr_i == 8'h04 |-> (prdata_o & 32'hFFFFF9C8) == 32'h0)
      else $error("status reserved bit set");
endmodule

bind dcps_top dcps_properties u_props (
   .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o));

// >>> testbench/dcps_pin_load.sv
// Output load model: samples one channel pin once per PWM tick
module dcps_pin_load (
   input  wire logic pwm_clk_i,
   input  wire logic pin_i,
   output logic [7:0] hist_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Sampled a full tick after launch, so the bit has long settled
   always @(posedge pwm_clk_i) begin
      hist_o <= {hist_o[6:0], pin_i};
   end
endmodule

// >>> testbench/test_dual_channel_pwm_serialiser.sv
// Self-checking bench for the two-channel PWM serialiser
module test_dual_channel_pwm_serialiser;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [15:0] ctl;
      logic [7:0]  rng;
      logic [31:0] d1;
      logic [31:0] d2;
      logic [7:0]  e1;
      logic [7:0]  e2;
   } dcps_row_t;
   logic        clk, nrst, pclk, psel, pen, pwr, pready, perr, ch1, ch2, qe;
   logic [7:0]  paddr, h1, h2;
   logic [31:0] pwdata, prdata, q;
   int          failures, checks_done;
   logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h30};
   logic [31:0] rv [9] = '{32'h0, 32'h2, 32'h707, 32'h20, 32'h0, 32'h0, 32'h20, 32'h0, 32'h0};
   dcps_row_t   rows [8] = '{
      '{16'h0303, 8'h04, 32'hA0000000, 32'hC0000000, 8'hAA, 8'hCC},
      '{16'h0101, 8'h08, 32'h2, 32'h4, 8'h11, 8'h55},
      '{16'h8181, 8'h08, 32'h3, 32'h1, 8'hE0, 8'h80},
      '{16'h8383, 8'h04, 32'hC0000000, 32'hA0000000, 8'hCC, 8'hAA},
      '{16'h1313, 8'h08, 32'h80000000, 32'h01000000, 8'h7F, 8'hFE},
      '{16'h0808, 8'h08, 32'h0, 32'h0, 8'hFF, 8'hFF},
      '{16'h1818, 8'h08, 32'h0, 32'h0, 8'h00, 8'h00},
      '{16'h0303, 8'h02, 32'h40000000, 32'hC0000000, 8'h55, 8'hFF}};

   dcps_top uut (.sys_clk_i(clk), .nrst_i(nrst), .pwm_clk_i(pclk), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .ch1_pwm_o(ch1),
      .ch2_pwm_o(ch2));
   dcps_pin_load load1 (.pwm_clk_i(pclk), .pin_i(ch1), .hist_o(h1));
   dcps_pin_load load2 (.pwm_clk_i(pclk), .pin_i(ch2), .hist_o(h2));

   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   // Slow tick keeps the output pipeline well inside one bit
   initial begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(negedge clk);
      psel = 1;
      pwr = w;
      paddr = a;
      pwdata = d;
      @(negedge clk);
      pen = 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 8);
      if (pready !== 1'b1) chk(32'h0, 32'h1);
      q = prdata;
      qe = perr;
      @(negedge clk);
      psel = 0;
      pen = 0;
   endtask

   task automatic do_reset;
      nrst = 0;
      repeat (5) @(negedge clk);
      nrst = 1;
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Bit streams have unknown phase, so accept any rotation
   function automatic logic [7:0] rot_fit(input logic [7:0] s, input logic [7:0] e);
      logic [7:0] t;
      for (int r = 0; r < 8; r++) begin
         t = (e << r) | (e >> (8 - r));
         if (t === s) return s;
      end
      return e;
   endfunction

   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Whole run is near 10 us; a generous bound catches a hung handshake
   initial begin
      #100000;
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      {nrst, psel, pen, pwr, paddr, pwdata, failures, checks_done} = '0;
      do_reset();
      for (int i = 0; i < 9; i++) begin
         bus(0, ra[i], 32'h0);
         chk(q, rv[i]);
         chk({31'h0, qe}, {31'h0, ra[i] == 8'h30});
      end
      bus(1, 8'h30, 32'h0);
      chk({31'h0, qe}, 32'h0);
      bus(1, 8'h00, 32'hFFFFFFFF);
      bus(0, 8'h00, 32'h0);
      chk(q, 32'h0000BFBF);
      $display("register map done");
      foreach (rows[i]) begin
         bus(1, 8'h00, 32'h0); // Stop first, so counter and accumulator restart clean
         bus(1, 8'h10, {24'h0, rows[i].rng});
         bus(1, 8'h20, {24'h0, rows[i].rng});
         bus(1, 8'h14, rows[i].d1);
         bus(1, 8'h24, rows[i].d2);
         bus(1, 8'h00, {16'h0, rows[i].ctl});
         ticks(14);
         chk({24'h0, h1}, {24'h0, rot_fit(h1, rows[i].e1)});
         chk({24'h0, h2}, {24'h0, rot_fit(h2, rows[i].e2)});
         $display("row %0d done", i);
      end
      bus(1, 8'h00, 32'h0);
      for (int i = 0; i < 70; i++) bus(1, 8'h18, 32'(i));
      bus(0, 8'h04, 32'h0);
      chk(q & 32'h7, 32'h5);
      bus(1, 8'h04, 32'h0);
      bus(0, 8'h04, 32'h0);
      chk(q & 32'h4, 32'h4);
      bus(1, 8'h04, 32'h4);
      bus(0, 8'h04, 32'h0);
      chk(q & 32'h4, 32'h0);
      bus(1, 8'h00, 32'h40);
      bus(0, 8'h04, 32'h0);
      chk(q & 32'h7, 32'h2);
      $display("queue limits done");
      bus(1, 8'h10, 32'h8);
      bus(1, 8'h20, 32'h8);
      for (int i = 0; i < 6; i++) bus(1, 8'h18, i[0] ? 32'h0F000000 : 32'hA5000000);
      bus(1, 8'h00, 32'h2B2B);
      ticks(14);
      chk({24'h0, h1}, {24'h0, rot_fit(h1, 8'hA5)});
      chk({24'h0, h2}, {24'h0, rot_fit(h2, 8'h0F)});
      ticks(40);
      chk({16'h0, h2, h1}, 32'hFFFF);
      bus(0, 8'h04, 32'h0);
      chk(q & 32'h30, 32'h30);
      $display("shared queue done");
      bus(1, 8'h00, 32'h40);
      bus(1, 8'h04, 32'h34);
      bus(1, 8'h18, 32'h3C000000);
      bus(1, 8'h00, 32'h27);
      ticks(40);
      chk({24'h0, h1}, {24'h0, rot_fit(h1, 8'h3C)});
      chk({24'h0, h2}, 32'h0);
      bus(0, 8'h04, 32'h0);
      chk(q & 32'h10, 32'h0);
      $display("hold last word done");
      do_reset();
      bus(0, 8'h00, 32'h0);
      chk(q, 32'h0);
      chk({30'h0, ch2, ch1}, 32'h0);
      $display("second reset done");
      report_and_stop();
   end
endmodule
